/* File: host_model.sv */
// Host side model that writes the four local mailboxes
`timescale 1ns/1ps
module host_model (
  input  wire logic       sys_clk_i,
  output logic      [3:0] host_mbox_wr_o
);
  initial host_mbox_wr_o = 4'h0;
  // One-cycle write pulse; several mailboxes may be hit at once
  task automatic put(input logic [3:0] m);
    host_mbox_wr_o = m;
    @(posedge sys_clk_i);
    #1 host_mbox_wr_o = 4'h0;
  endtask : put
endmodule : host_model

/* File: local_mailbox_irq_ctrl.sv */
// Local mailbox interrupt enable and pending register with irq output
`timescale 1ns/1ps
`include "mbox_irq_cfg.svh"

// Notes on behaviour
// - Enable bits 7..4 map mailboxes 3..0; enabled host write raises irq.
// - Disabled mailboxes never raise irq; enables reset to zero.
// - Pending bits 3..0 map mailboxes 3..0; one means pending; reset zero.
// - Local side reads and writes enables; host sees read-only copy.
module local_mailbox_irq_ctrl (
  input  wire logic                       sys_clk_i,
  input  wire logic                       rstn_i,
  input  wire logic [3:0]                 host_mbox_wr_i,
  input  wire logic                       loc_wr_i,
  input  wire logic [7:0]                 loc_wdata_i,
  output logic      [7:0]                 loc_rdata_o,
  output logic      [7:0]                 host_rdata_o,
  output logic                            loc_irq_o
);

  // Reset release pipeline; only the second stage feeds the logic
  logic                       rst_meta_q;
  logic                       rst_sync_q;

  // Enable field, rewritten whole on every local write
  mbox_irq_pkg::mbox_vec_type enable_q;
  mbox_irq_pkg::mbox_vec_type enable_d;

  // Pending flags, one per mailbox
  mbox_irq_pkg::mbox_vec_type pending_q;
  mbox_irq_pkg::mbox_vec_type pending_d;

  // Fields of the local write word and the qualified host writes
  mbox_irq_pkg::mbox_vec_type wr_enable;
  mbox_irq_pkg::mbox_vec_type wr_clear;
  mbox_irq_pkg::mbox_vec_type set_hit;
  mbox_irq_pkg::mbox_vec_type clr_hit;
  logic                       any_set;

  // Registered image seen by both sides, and the irq line
  mbox_irq_pkg::reg_byte_type rdata_q;
  mbox_irq_pkg::reg_byte_type rdata_d;
  logic                       irq_q;
  logic                       irq_d;

  // Reset release through two flops so deassertion is clean
  always_ff @(posedge sys_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      rst_meta_q <= 1'h0;
      rst_sync_q <= 1'h0;
    end else begin
      rst_meta_q <= 1'h1;
      rst_sync_q <= rst_meta_q;
    end
  end

  // Split the local write word into its two fields
  assign wr_enable = loc_wdata_i[`ENABLE_LSB +: `MBOX_COUNT];
  assign wr_clear  = loc_wdata_i[`PENDING_LSB +: `MBOX_COUNT];

  // disabled mailboxes masked; the enables before a write decide
  assign set_hit = host_mbox_wr_i & enable_q;
  // Any qualified host write, kept for the irq checks
  assign any_set = |set_hit;

  assign clr_hit = wr_clear & {`MBOX_COUNT{loc_wr_i}};

  always_comb begin
    enable_d = enable_q;
    if (loc_wr_i) begin
      enable_d = wr_enable;
    end
  end

  // Enable register; the host has no write path, so it stays read-only
  always_ff @(posedge sys_clk_i or negedge rst_sync_q) begin
    if (!rst_sync_q) begin
      enable_q <= `ENABLE_RESET;
    end else begin
      enable_q <= enable_d;
    end
  end

  // clear first, then set, so an event in the clear cycle is kept
  always_comb begin
    pending_d = pending_q & ~clr_hit;
    pending_d = pending_d | set_hit;
  end

  // pending flags clear out of reset
  always_ff @(posedge sys_clk_i or negedge rst_sync_q) begin
    if (!rst_sync_q) begin
      pending_q <= `PENDING_RESET;
    end else begin
      pending_q <= pending_d;
    end
  end

  // image built from next values so it never lags the flags
  always_comb begin
    rdata_d = {enable_d, pending_d};
    irq_d   = |pending_d;
  end

  // Image and irq flops; outputs come straight from them
  always_ff @(posedge sys_clk_i or negedge rst_sync_q) begin
    if (!rst_sync_q) begin
      rdata_q <= `CTRL_STATUS_RESET;
      irq_q   <= `IRQ_RESET;
    end else begin
      rdata_q <= rdata_d;
      irq_q   <= irq_d;
    end
  end

  // Both sides read the same flops; no read strobe is needed
  assign loc_rdata_o  = rdata_q;
  assign host_rdata_o = rdata_q;
  assign loc_irq_o    = irq_q;

  // Set by enabled host write within one cycle
  property set_pend_p;
    @(posedge sys_clk_i) disable iff (!rst_sync_q)
      (host_mbox_wr_i[0] && enable_q[0]) |=> pending_q[0];
  endproperty
  pend_set_a: assert property (set_pend_p)
    else $error("enabled host write did not set pending");

  pend_masked_a: assert property (
    @(posedge sys_clk_i) disable iff (!rst_sync_q)
      (!enable_q[1] && !pending_q[1] && !(loc_wr_i)) |=> !pending_q[1])
    else $error("disabled mailbox raised pending");

  irq_follows_a: assert property (
    @(posedge sys_clk_i) disable iff (!rst_sync_q)
      loc_irq_o == (|pending_q))
    else $error("irq does not reflect pending");

  en_write_a: assert property (
    @(posedge sys_clk_i) disable iff (!rst_sync_q)
      loc_wr_i |=> enable_q == $past(wr_enable))
    else $error("enable write not stored");

  w1c_clear_a: assert property (
    @(posedge sys_clk_i) disable iff (!rst_sync_q)
      (loc_wr_i && loc_wdata_i[2] && !host_mbox_wr_i[2]) |=> !pending_q[2])
    else $error("write one did not clear pending");

  // Enables move only on a local write
  en_hold_a: assert property (
    @(posedge sys_clk_i) disable iff (!rst_sync_q)
      !loc_wr_i |=> $stable(enable_q))
    else $error("enable field changed without a local write");

  // Reset clears both images; checked while reset is held on purpose
  reset_zero_a: assert property (
    @(posedge sys_clk_i)
      !rst_sync_q |-> (loc_rdata_o == `CTRL_STATUS_RESET && !loc_irq_o &&
                       host_rdata_o == `CTRL_STATUS_RESET))
    else $error("register image not clear under reset");

  // The irq only rises after a qualified host write
  irq_rise_a: assert property (
    @(posedge sys_clk_i) disable iff (!rst_sync_q)
      $rose(loc_irq_o) |-> $past(any_set))
    else $error("irq rose without an enabled host write");

  // The irq only falls after a local write
  irq_fall_a: assert property (
    @(posedge sys_clk_i) disable iff (!rst_sync_q)
      $fell(loc_irq_o) |-> $past(loc_wr_i))
    else $error("irq fell without a local write");

  // Per-mailbox checks; the sequences name what moves one pending flag
  genvar g;
  generate
    for (g = 0; g < `MBOX_COUNT; g++) begin : g_mbox_chk
      // Enabled host write to this mailbox
      sequence host_hit_s;
        host_mbox_wr_i[g] && enable_q[g];
      endsequence
      // Local write of one with no qualified host write beside it
      sequence local_clr_s;
        loc_wr_i && wr_clear[g] && !(host_mbox_wr_i[g] && enable_q[g]);
      endsequence
      // Flag up and no local clear aimed at it
      sequence kept_s;
        pending_q[g] && !(loc_wr_i && wr_clear[g]);
      endsequence
      // Clear and set land in the same cycle
      sequence clash_s;
        loc_wr_i && wr_clear[g] && host_mbox_wr_i[g] && enable_q[g];
      endsequence

      // Set raises the flag and the irq
      mb_set_a: assert property (
        @(posedge sys_clk_i) disable iff (!rst_sync_q)
          host_hit_s |=> (pending_q[g] && loc_irq_o))
        else $error("enabled host write raised no pending irq");

      // Nothing but a qualified host write sets the flag
      mb_mask_a: assert property (
        @(posedge sys_clk_i) disable iff (!rst_sync_q)
          (!pending_q[g] && !(host_mbox_wr_i[g] && enable_q[g]))
            |=> !pending_q[g])
        else $error("pending set without an enabled host write");

      // Both images show the new flag at its bit
      mb_image_a: assert property (
        @(posedge sys_clk_i) disable iff (!rst_sync_q)
          host_hit_s |=> (loc_rdata_o[`PENDING_LSB + g] &&
                          host_rdata_o[`PENDING_LSB + g]))
        else $error("pending bit missing from the register image");

      // A write of one clears the flag
      mb_clear_a: assert property (
        @(posedge sys_clk_i) disable iff (!rst_sync_q)
          local_clr_s |=> !pending_q[g])
        else $error("write of one left the pending flag set");

      // A write of zero leaves the flag alone
      mb_keep_a: assert property (
        @(posedge sys_clk_i) disable iff (!rst_sync_q)
          kept_s |=> pending_q[g])
        else $error("pending flag lost without a clear");

      // A set in the clear cycle wins
      mb_win_a: assert property (
        @(posedge sys_clk_i) disable iff (!rst_sync_q)
          clash_s |=> pending_q[g])
        else $error("clear beat a host write in the same cycle");

      // Set then clear returns the image bit to zero
      mb_cycle_a: assert property (
        @(posedge sys_clk_i) disable iff (!rst_sync_q)
          host_hit_s ##1 local_clr_s |=> !loc_rdata_o[`PENDING_LSB + g])
        else $error("set then clear left the image bit set");
    end
  endgenerate

endmodule : local_mailbox_irq_ctrl

/* File: local_mailbox_irq_ctrl_tb.sv */
// Testbench for the local mailbox interrupt control block
`timescale 1ns/1ps
module local_mailbox_irq_ctrl_tb;
  logic       sys_clk_i = 1'h0;
  logic       rstn_i = 1'h0;
  logic       loc_wr_i = 1'h0;
  logic [7:0] loc_wdata_i = 8'h00;
  logic [3:0] host_wr;
  logic [7:0] loc_rdata_o, host_rdata_o;
  logic       loc_irq_o;
  int         n_errors = 0;
  int         tests_run = 0;
  initial begin
    forever #2 sys_clk_i = ~sys_clk_i;
  end
  host_model i_host (.sys_clk_i(sys_clk_i), .host_mbox_wr_o(host_wr));
  local_mailbox_irq_ctrl i_dut (.sys_clk_i(sys_clk_i), .rstn_i(rstn_i),
    .host_mbox_wr_i(host_wr), .loc_wr_i(loc_wr_i), .loc_wdata_i(loc_wdata_i),
    .loc_rdata_o(loc_rdata_o), .host_rdata_o(host_rdata_o),
    .loc_irq_o(loc_irq_o));
  task automatic wrap_up;
    if (n_errors == 0 && tests_run > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : wrap_up
  // Count one comparison and report it if seen and expected differ
  task automatic check(input string what, input logic [7:0] seen,
                       input logic [7:0] expected);
    tests_run++;
    if (seen !== expected) begin
      n_errors++;
      $display("CHECK FAILED %s exp %h got %h", what, expected, seen);
    end
  endtask : check
  // Both images must match and the irq must follow any pending bit
  task automatic ck(input logic [7:0] e);
    check("loc_image", loc_rdata_o, e);
    check("host_image", host_rdata_o, e);
    check("loc_irq", {7'h00, loc_irq_o}, {7'h00, |e[3:0]});
  endtask : ck
  // Local register write, one strobe cycle
  task automatic lw(input logic [7:0] d);
    loc_wr_i = 1'h1;
    loc_wdata_i = d;
    @(posedge sys_clk_i);
    #1 loc_wr_i = 1'h0;
  endtask : lw
  // Hang guard: the sequence needs well under a hundred cycles
  initial begin
    #2000;
    n_errors++;
    wrap_up();
  end
  initial begin
    repeat (16) @(posedge sys_clk_i);
    #1 rstn_i = 1'b1;
    repeat (3) @(posedge sys_clk_i);
    #1 ck(8'h00);
    i_host.put(4'hF);
    ck(8'h00);
    lw(8'hA0);
    ck(8'hA0);
    i_host.put(4'hF);
    ck(8'hAA);
    lw(8'hA8);
    ck(8'hA2);
    lw(8'hF2);
    ck(8'hF0);
    i_host.put(4'h4);
    ck(8'hF4);
    i_host.put(4'h1);
    ck(8'hF5);
    // Clear and host write of mailbox 0 in one cycle: the set is kept
    fork
      i_host.put(4'h1);
      lw(8'hF5);
    join
    ck(8'hF1);
    // Reset in mid-run returns every field to zero
    rstn_i = 1'h0;
    repeat (2) @(posedge sys_clk_i);
    #1 ck(8'h00);
    rstn_i = 1'h1;
    repeat (3) @(posedge sys_clk_i);
    #1 i_host.put(4'hF);
    ck(8'h00);
    lw(8'h10);
    i_host.put(4'h1);
    ck(8'h11);
    lw(8'h11);
    ck(8'h10);
    wrap_up();
  end
endmodule : local_mailbox_irq_ctrl_tb

/* File: mbox_irq_cfg.svh */
// Register offsets, field positions and reset values of the mailbox irq block
`ifndef MBOX_IRQ_CFG_SVH
`define MBOX_IRQ_CFG_SVH

`define MBOX_COUNT        4
`define CTRL_STATUS_OFS   9'h100
`define ENABLE_LSB        4
`define PENDING_LSB       0
`define CTRL_STATUS_RESET 8'h00
`define ENABLE_RESET      4'h0
`define PENDING_RESET     4'h0
`define IRQ_RESET         1'h0

`endif

/* File: mbox_irq_pkg.sv */
// Types shared by the mailbox interrupt control block
package mbox_irq_pkg;
  typedef logic [3:0] mbox_vec_type;
  typedef logic [7:0] reg_byte_type;
endpackage : mbox_irq_pkg
